// File: core/pcsi_core.sv
`timescale 1ns/1ns
// Contract
// - call: low eleven bits operand, rest latch
// - computed call: latch high, working low
// - register branch: incremented counter plus unsigned working
// - immediate branch: incremented counter plus signed operand
// - sixteen by fifteen stack outside address spaces
// - push on calls, vectoring; pop on returns
// - push and pop leave latch untouched
// - fault reset off: stack wraps circularly
// - overflow and underflow flags always set
// - top entry registers follow stack pointer
// - five bit pointer marks entry in use
// - push increments then writes; pop reads then decrements
// - fault reset on: overflow or underflow resets
// - indirect to indirect: read zero, write dropped
// - pointer is high and low byte
// - low region maps to absolute data addresses
// - linear region walks eighty byte blocks
// - unimplemented indirect reads return zero
// - linear region skips common memory
// - top pointer bit selects flash, low byte
// - indirect writes never alter flash
// - flash access costs one extra cycle
// - fifteen bit counter cleared on reset
// - low byte write loads upper bits from latch
module pcsi_core #(
  parameter logic [14:0] VECTOR_ADDR = 15'h0004
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire pcsi_pkg::pcsi_op_e op_code,
  input wire logic [pcsi_pkg::PCSI_OPND_W-1:0] op_operand,
  input wire logic [pcsi_pkg::PCSI_ADDR_W-1:0] reg_addr,
  input wire logic [pcsi_pkg::PCSI_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcsi_pkg::PCSI_DATA_W-1:0] reg_rdata,
  output logic [pcsi_pkg::PCSI_PC_W-1:0] pc,
  output logic [pcsi_pkg::PCSI_ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [pcsi_pkg::PCSI_DATA_W-1:0] mem_wdata,
  input wire logic [pcsi_pkg::PCSI_DATA_W-1:0] mem_rdata,
  output logic [pcsi_pkg::PCSI_PC_W-1:0] flash_addr,
  output logic flash_rd,
  input wire logic [pcsi_pkg::PCSI_FLASH_W-1:0] flash_rdata,
  output logic flash_stall,
  output logic stack_reset_req
);
  import pcsi_pkg::*;

  logic [PCSI_PC_W-1:0] pc_q;
  logic [PCSI_PC_W-1:0] pc_d;
  logic [6:0] latch_q;
  logic [PCSI_DATA_W-1:0] working_q;
  logic [PCSI_FSR_W-1:0] fsr0_q;
  logic [PCSI_FSR_W-1:0] fsr1_q;
  logic [PCSI_SP_W-1:0] sp_q;
  logic [PCSI_SP_W-1:0] sp_d;
  logic ovf_q;
  logic unf_q;
  logic fault_en_q;
  logic [PCSI_DATA_W-1:0] rdata_q;
  logic stall_q;
  logic reset_req_q;
  logic [PCSI_PC_W-1:0] top_entry;
  logic [PCSI_DATA_W-1:0] rd_mux;

  // instruction decode
  wire op_call = op_valid && (op_code == OP_CALL);
  wire op_ccall = op_valid && (op_code == OP_COMPUTED_CALL);
  wire op_vector = op_valid && (op_code == OP_VECTOR);
  wire op_ret_lit = op_valid && (op_code == OP_RETURN_LITERAL);
  wire is_push = op_call || op_ccall || op_vector;
  wire is_pop = op_valid && (op_code == OP_RETURN || op_code == OP_RETURN_INTERRUPT
    || op_code == OP_RETURN_LITERAL);

  // overflow is a push from the top level, underflow a pop from empty
  wire push_ovf = is_push && (sp_q == SP_TOP);
  wire pop_unf = is_pop && (sp_q == SP_EMPTY);
  wire fault = fault_en_q && (push_ovf || pop_unf);

  // pointer moves: increment before write, decrement after read
  wire [PCSI_SP_W-1:0] sp_push = push_ovf ? SP_WRAP : PCSI_SP_W'(sp_q + 5'h01);
  wire [3:0] unf_idx = 4'(sp_q[3:0] - 4'h1);
  wire [PCSI_SP_W-1:0] sp_pop = pop_unf ? {1'b0, unf_idx} : PCSI_SP_W'(sp_q - 5'h01);

  // register port decode
  wire sel_indf0 = (reg_addr == ADR_INDF0);
  wire sel_indf1 = (reg_addr == ADR_INDF1);
  wire sel_indf = sel_indf0 || sel_indf1;
  wire wr_pcl = reg_wr && (reg_addr == ADR_COUNTER_LOW);
  wire wr_fsr0l = reg_wr && (reg_addr == ADR_FSR0_LOW);
  wire wr_fsr0h = reg_wr && (reg_addr == ADR_FSR0_HIGH);
  wire wr_fsr1l = reg_wr && (reg_addr == ADR_FSR1_LOW);
  wire wr_fsr1h = reg_wr && (reg_addr == ADR_FSR1_HIGH);
  wire wr_work = reg_wr && (reg_addr == ADR_WORKING);
  wire wr_latch = reg_wr && (reg_addr == ADR_HIGH_LATCH);
  wire wr_sp = reg_wr && (reg_addr == ADR_STACK_PTR);
  wire wr_top_entry_low = reg_wr && (reg_addr == ADR_TOP_LOW);
  wire wr_top_entry_high = reg_wr && (reg_addr == ADR_TOP_HIGH);
  wire wr_ctrl = reg_wr && (reg_addr == ADR_STACK_CTRL);
  wire wr_flags = reg_wr && (reg_addr == ADR_STACK_FLAGS);

  // stack write: a push wins over a top-entry write in the same cycle
  wire tos_wr = wr_top_entry_low || wr_top_entry_high;
  wire [PCSI_PC_W-1:0] tos_merge = wr_top_entry_low ? {top_entry[14:8], reg_wdata}
    : {reg_wdata[6:0], top_entry[7:0]};
  wire stk_wr_en = (is_push && !fault) || tos_wr;
  wire [3:0] stk_wr_idx = is_push ? sp_push[3:0] : sp_q[3:0];
  wire [PCSI_PC_W-1:0] stk_wr_data = is_push ? pc_q : tos_merge;

  pcsi_stack #(
    .DEPTH(PCSI_DEPTH),
    .IDX_W(PCSI_IDX_W),
    .WIDTH(PCSI_PC_W)
  ) u_stack (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(stk_wr_en),
    .wr_idx(stk_wr_idx),
    .wr_data(stk_wr_data),
    .rd_idx(sp_q[3:0]),
    .rd_data(top_entry)
  );

  // branch and call targets; pc_q already holds the incremented counter
  wire [PCSI_PC_W-1:0] call_target = {latch_q[6:3], op_operand};
  wire [PCSI_PC_W-1:0] ccall_target = {latch_q, working_q};
  wire [PCSI_PC_W-1:0] reg_br_target = PCSI_PC_W'(pc_q + {7'h00, working_q});
  wire [PCSI_PC_W-1:0] rel_ext = {{(PCSI_PC_W-PCSI_REL_W){op_operand[PCSI_REL_W-1]}},
    op_operand[PCSI_REL_W-1:0]};
  wire [PCSI_PC_W-1:0] imm_br_target = PCSI_PC_W'(pc_q + rel_ext);
  wire [PCSI_PC_W-1:0] step_target = PCSI_PC_W'(pc_q + 15'h0001);
  wire [PCSI_PC_W-1:0] pcl_target = {latch_q, reg_wdata};

  // instructions win over a register-port write of the low byte
  always_comb begin
    pc_d = pc_q;
    if (op_valid) begin
      case (op_code)
        OP_STEP: pc_d = step_target;
        OP_CALL: pc_d = call_target;
        OP_COMPUTED_CALL: pc_d = ccall_target;
        OP_REG_BRANCH: pc_d = reg_br_target;
        OP_IMM_BRANCH: pc_d = imm_br_target;
        OP_RETURN: pc_d = top_entry;
        OP_RETURN_LITERAL: pc_d = top_entry;
        OP_RETURN_INTERRUPT: pc_d = top_entry;
        OP_VECTOR: pc_d = VECTOR_ADDR;
        default: pc_d = pc_q;
      endcase
    end else if (wr_pcl) begin
      pc_d = pcl_target;
    end
    if (fault) begin
      pc_d = PC_RESET;
    end
  end

  always_comb begin
    sp_d = sp_q;
    if (fault) begin
      sp_d = SP_EMPTY;
    end else if (is_push) begin
      sp_d = sp_push;
    end else if (is_pop) begin
      sp_d = sp_pop;
    end else if (wr_sp) begin
      sp_d = reg_wdata[PCSI_SP_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_q <= PC_RESET;
      sp_q <= SP_EMPTY;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
    end
  end

  // latch is written only by software; stack traffic never touches it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_q <= '0;
    end else if (wr_latch) begin
      latch_q <= reg_wdata[6:0];
    end
  end

  // a literal return also loads the working register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      working_q <= '0;
    end else if (op_ret_lit) begin
      working_q <= op_operand[PCSI_DATA_W-1:0];
    end else if (wr_work) begin
      working_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fsr0_q <= '0;
      fsr1_q <= '0;
    end else begin
      if (wr_fsr0l) fsr0_q[7:0] <= reg_wdata;
      if (wr_fsr0h) fsr0_q[15:8] <= reg_wdata;
      if (wr_fsr1l) fsr1_q[7:0] <= reg_wdata;
      if (wr_fsr1h) fsr1_q[15:8] <= reg_wdata;
    end
  end

  // flags clear by writing zero; a new fault in the same cycle still sets
  wire ovf_keep = ovf_q && !(wr_flags && !reg_wdata[FLAG_OVF_BIT]);
  wire unf_keep = unf_q && !(wr_flags && !reg_wdata[FLAG_UNF_BIT]);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      fault_en_q <= FAULT_EN_RESET;
      reset_req_q <= 1'b0;
    end else begin
      ovf_q <= ovf_keep || push_ovf;
      unf_q <= unf_keep || pop_unf;
      reset_req_q <= fault;
      if (wr_ctrl) fault_en_q <= reg_wdata[CTRL_FAULT_EN_BIT];
    end
  end

  // indirect access through the selected pointer
  wire [PCSI_FSR_W-1:0] fsr_sel = sel_indf1 ? fsr1_q : fsr0_q;
  wire ind_rd = reg_rd && sel_indf;
  wire ind_wr = reg_wr && sel_indf;
  wire in_flash = fsr_sel[FSR_FLASH_BIT];
  wire in_trad = (fsr_sel[15:12] == FSR_TRAD_TOP);
  wire in_lin = (fsr_sel >= FSR_LIN_BASE) && (fsr_sel <= FSR_LIN_LAST);
  wire hits_indf = in_trad && (fsr_sel[6:0] <= INDF_LAST_LOW);
  wire data_ok = (in_trad && !hits_indf) || in_lin;

  // linear offset split into bank and position inside the gpr block;
  // constant divide keeps it one cycle at the cost of some area
  wire [11:0] lin_off = 12'(fsr_sel - FSR_LIN_BASE);
  wire [11:0] lin_bank = 12'(lin_off / LIN_BLOCK);
  wire [11:0] lin_pos = 12'(lin_off % LIN_BLOCK);
  wire [6:0] lin_low = 7'(lin_pos[6:0] + GPR_OFFSET);
  wire [PCSI_ADDR_W-1:0] lin_abs = {lin_bank[4:0], lin_low};

  assign mem_addr = in_lin ? lin_abs : fsr_sel[PCSI_ADDR_W-1:0];
  assign mem_rd = ind_rd && data_ok && !in_flash;
  assign mem_wr = ind_wr && data_ok && !in_flash;
  assign mem_wdata = reg_wdata;
  assign flash_addr = fsr_sel[PCSI_PC_W-1:0];
  assign flash_rd = ind_rd && in_flash;

  // reserved regions and indirect-to-indirect read as zero
  wire [PCSI_DATA_W-1:0] ind_value = in_flash ? flash_rdata[PCSI_DATA_W-1:0]
    : (data_ok ? mem_rdata : BYTE_ZERO);

  always_comb begin
    case (reg_addr)
      ADR_INDF0: rd_mux = ind_value;
      ADR_INDF1: rd_mux = ind_value;
      ADR_COUNTER_LOW: rd_mux = pc_q[7:0];
      ADR_FSR0_LOW: rd_mux = fsr0_q[7:0];
      ADR_FSR0_HIGH: rd_mux = fsr0_q[15:8];
      ADR_FSR1_LOW: rd_mux = fsr1_q[7:0];
      ADR_FSR1_HIGH: rd_mux = fsr1_q[15:8];
      ADR_WORKING: rd_mux = working_q;
      ADR_HIGH_LATCH: rd_mux = {1'b0, latch_q};
      ADR_STACK_PTR: rd_mux = {3'b000, sp_q};
      ADR_TOP_LOW: rd_mux = top_entry[7:0];
      ADR_TOP_HIGH: rd_mux = {1'b0, top_entry[14:8]};
      ADR_STACK_CTRL: rd_mux = {7'h00, fault_en_q};
      ADR_STACK_FLAGS: rd_mux = {6'h00, unf_q, ovf_q};
      default: rd_mux = BYTE_ZERO;
    endcase
  end

  // read data stands one cycle only; zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= BYTE_ZERO;
      stall_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : BYTE_ZERO;
      stall_q <= (ind_rd || ind_wr) && in_flash;
    end
  end

  assign reg_rdata = rdata_q;
  assign pc = pc_q;
  assign flash_stall = stall_q;
  assign stack_reset_req = reset_req_q;

endmodule

// File: core/pcsi_pkg.sv
package pcsi_pkg;

  // widths
  localparam int PCSI_PC_W = 15;
  localparam int PCSI_DATA_W = 8;
  localparam int PCSI_ADDR_W = 12;
  localparam int PCSI_SP_W = 5;
  localparam int PCSI_DEPTH = 16;
  localparam int PCSI_IDX_W = 4;
  localparam int PCSI_FSR_W = 16;
  localparam int PCSI_OPND_W = 11;
  localparam int PCSI_REL_W = 9;
  localparam int PCSI_FLASH_W = 14;

  // register addresses on the register port
  localparam logic [11:0] ADR_INDF0 = 12'hF80;
  localparam logic [11:0] ADR_INDF1 = 12'hF81;
  localparam logic [11:0] ADR_COUNTER_LOW = 12'hF82;
  localparam logic [11:0] ADR_FSR0_LOW = 12'hF84;
  localparam logic [11:0] ADR_FSR0_HIGH = 12'hF85;
  localparam logic [11:0] ADR_FSR1_LOW = 12'hF86;
  localparam logic [11:0] ADR_FSR1_HIGH = 12'hF87;
  localparam logic [11:0] ADR_WORKING = 12'hF89;
  localparam logic [11:0] ADR_HIGH_LATCH = 12'hF8A;
  localparam logic [11:0] ADR_STACK_PTR = 12'hFED;
  localparam logic [11:0] ADR_TOP_LOW = 12'hFEE;
  localparam logic [11:0] ADR_TOP_HIGH = 12'hFEF;
  localparam logic [11:0] ADR_STACK_CTRL = 12'hFF0;
  localparam logic [11:0] ADR_STACK_FLAGS = 12'hFF1;

  // field positions
  localparam int CTRL_FAULT_EN_BIT = 0;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_UNF_BIT = 1;
  localparam int FSR_FLASH_BIT = 15;

  // reset values and stack pointer limits
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [4:0] SP_EMPTY = 5'h1F;
  localparam logic [4:0] SP_TOP = 5'h0F;
  localparam logic [4:0] SP_WRAP = 5'h00;
  localparam logic FAULT_EN_RESET = 1'b1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // indirect address map
  localparam logic [3:0] FSR_TRAD_TOP = 4'h0;
  localparam logic [15:0] FSR_LIN_BASE = 16'h2000;
  localparam logic [15:0] FSR_LIN_LAST = 16'h29AF;
  localparam logic [11:0] LIN_BLOCK = 12'h050;
  localparam logic [6:0] GPR_OFFSET = 7'h20;
  localparam logic [6:0] INDF_LAST_LOW = 7'h01;

  typedef enum logic [3:0] {
    OP_STEP,
    OP_CALL,
    OP_COMPUTED_CALL,
    OP_REG_BRANCH,
    OP_IMM_BRANCH,
    OP_RETURN,
    OP_RETURN_LITERAL,
    OP_RETURN_INTERRUPT,
    OP_VECTOR
  } pcsi_op_e;

endpackage

// File: core/pcsi_stack.sv
`timescale 1ns/1ns
module pcsi_stack #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4,
  parameter int WIDTH = 15
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  import pcsi_pkg::*;

  logic [WIDTH-1:0] entry_q [DEPTH];

  // kept outside program and data space: only the pointer reaches it
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    wire hit = wr_en && (wr_idx == IDX_W'(i));
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        entry_q[i] <= '0;
      end else if (hit) begin
        entry_q[i] <= wr_data;
      end
    end
  end

  assign rd_data = entry_q[rd_idx];

endmodule

// File: tb/pcsi_mem_model.sv
`timescale 1ns/1ns
module pcsi_mem_model (
  input wire logic sys_clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input wire logic [14:0] flash_addr,
  input wire logic flash_rd,
  output logic [13:0] flash_rdata
);
  logic [7:0] ram [0:4095];
  logic [13:0] junk = 14'h2A5C;
  // unread buses churn so stale data never looks valid
  always @(posedge sys_clk) begin
    junk <= junk + 14'h1357;
    if (mem_wr) begin
      ram[mem_addr] <= mem_wdata;
    end
  end
  assign mem_rdata = mem_rd ? ram[mem_addr] : junk[7:0];
  // flash is read only here, no write path at all
  assign flash_rdata = flash_rd ? {flash_addr[13:8], flash_addr[7:0] ^ 8'h5A} : junk;
endmodule

// File: tb/pcsi_checker.sv
`timescale 1ns/1ns
module pcsi_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire pcsi_pkg::pcsi_op_e op_code,
  input wire logic [10:0] op_operand,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [14:0] pc,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic flash_rd,
  input wire logic [13:0] flash_rdata,
  input wire logic flash_stall,
  input wire logic stack_reset_req
);
  import pcsi_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_call_target: assert property (
    op_valid && op_code == OP_CALL |=> stack_reset_req || pc[10:0] == $past(op_operand))
    else $error("call target wrong");
  a_branch_offset: assert property (
    op_valid && op_code == OP_IMM_BRANCH |=>
    pc == $past(pc) + {{6{$past(op_operand[8])}}, $past(op_operand[8:0])})
    else $error("branch target wrong");
  a_step_count: assert property (
    op_valid && op_code == OP_STEP |=> pc == $past(pc) + 15'h0001)
    else $error("step did not advance");
  a_mem_data: assert property (
    reg_rd && mem_rd |=> reg_rdata == $past(mem_rdata))
    else $error("indirect data lost");
  a_flash_byte: assert property (
    reg_rd && flash_rd |=> reg_rdata == $past(flash_rdata[7:0]))
    else $error("flash byte wrong");
  // a second access right behind may stall again, so only a quiet cycle ends it
  a_flash_stall: assert property (
    reg_rd && flash_rd ##1 !reg_rd && !reg_wr |-> flash_stall ##1 !flash_stall)
    else $error("flash stall missing");
  // writes through a pointer into flash stall as well
  a_stall_cause: assert property (
    flash_stall |-> $past(flash_rd || (reg_wr && !mem_wr
      && (reg_addr == ADR_INDF0 || reg_addr == ADR_INDF1))))
    else $error("stall without flash");
  a_write_path: assert property (
    mem_wr |-> reg_wr && !mem_rd && mem_wdata == reg_wdata)
    else $error("stray memory write");
  a_fault_pc: assert property (
    stack_reset_req |-> pc == PC_RESET ##1 !stack_reset_req)
    else $error("fault reset wrong");
  cover property (op_valid && op_code == OP_VECTOR);
  cover property (flash_stall);
  cover property (stack_reset_req);
endmodule

// File: tb/test_pc_stack_indirect_addressing.sv
`timescale 1ns/1ns
module test_pc_stack_indirect_addressing;
  import pcsi_pkg::*;
  logic sys_clk = 0;
  logic rst = 1;
  logic op_valid = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  pcsi_op_e op_code = OP_STEP;
  logic [10:0] op_operand = 11'h000;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, mem_wdata, mem_rdata;
  logic [14:0] pc, flash_addr;
  logic [11:0] mem_addr;
  logic mem_rd, mem_wr, flash_rd, flash_stall, stack_reset_req;
  logic [13:0] flash_rdata;
  int mismatches = 0;
  int samples_checked = 0;
  always #50 sys_clk = ~sys_clk;
  pcsi_core dut (.sys_clk, .rst, .op_valid, .op_code, .op_operand, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pc, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
    .flash_addr, .flash_rd, .flash_rdata, .flash_stall, .stack_reset_req);
  pcsi_mem_model far (.sys_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
    .flash_addr, .flash_rd, .flash_rdata);
  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_pc(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: counter %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp_byte(reg_rdata, e);
  endtask
  task op(input pcsi_op_e c, input logic [10:0] o);
    @(posedge sys_clk);
    op_code <= c;
    op_operand <= o;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    cmp_pc(pc, PC_RESET);
    rdc(ADR_STACK_PTR, 8'h1F);
    rdc(ADR_STACK_CTRL, 8'h01);
    rdc(12'hF83, 8'h00);
    wr(ADR_HIGH_LATCH, 8'h7A);
    op(OP_CALL, 11'h123);
    cmp_pc(pc, 15'h7923);
    rdc(ADR_STACK_PTR, 8'h00);
    rdc(ADR_TOP_LOW, 8'h00);
    rdc(ADR_HIGH_LATCH, 8'h7A);
    wr(ADR_WORKING, 8'h55);
    wr(ADR_HIGH_LATCH, 8'h12);
    op(OP_COMPUTED_CALL, 11'h000);
    cmp_pc(pc, 15'h1255);
    rdc(ADR_TOP_LOW, 8'h23);
    rdc(ADR_TOP_HIGH, 8'h79);
    op(OP_RETURN, 11'h000);
    cmp_pc(pc, 15'h7923);
    op(OP_RETURN_LITERAL, 11'h09C);
    cmp_pc(pc, 15'h0000);
    rdc(ADR_WORKING, 8'h9C);
    rdc(ADR_STACK_PTR, 8'h1F);
    wr(ADR_WORKING, 8'hF0);
    op(OP_REG_BRANCH, 11'h000);
    cmp_pc(pc, 15'h00F0);
    op(OP_IMM_BRANCH, 11'h1F0);
    cmp_pc(pc, 15'h00E0);
    op(OP_STEP, 11'h000);
    cmp_pc(pc, 15'h00E1);
    wr(ADR_COUNTER_LOW, 8'h34);
    cmp_pc(pc, 15'h1234);
    // wrap needs the fault reset off first
    wr(ADR_STACK_CTRL, 8'h00);
    for (int i = 0; i < 17; i++) begin
      op(OP_VECTOR, 11'h000);
      if (i == 0) begin
        rdc(ADR_STACK_FLAGS, 8'h00);
      end
    end
    rdc(ADR_STACK_PTR, 8'h00);
    rdc(ADR_TOP_LOW, 8'h04);
    rdc(ADR_STACK_FLAGS, 8'h01);
    wr(ADR_TOP_LOW, 8'h78);
    wr(ADR_TOP_HIGH, 8'h56);
    rdc(ADR_TOP_HIGH, 8'h56);
    op(OP_RETURN_INTERRUPT, 11'h000);
    cmp_pc(pc, 15'h5678);
    rdc(ADR_STACK_PTR, 8'h1F);
    wr(ADR_STACK_CTRL, 8'h01);
    wr(ADR_STACK_PTR, 8'h1F);
    op(OP_RETURN, 11'h000);
    cmp_byte({7'h00, stack_reset_req}, 8'h01);
    cmp_pc(pc, PC_RESET);
    rdc(ADR_STACK_FLAGS, 8'h03);
    wr(ADR_FSR0_HIGH, 8'h01);
    wr(ADR_FSR0_LOW, 8'h23);
    wr(ADR_INDF0, 8'h5A);
    rdc(ADR_INDF0, 8'h5A);
    wr(ADR_FSR1_HIGH, 8'h20);
    wr(ADR_FSR1_LOW, 8'h51);
    wr(ADR_INDF1, 8'h3C);
    wr(ADR_FSR0_HIGH, 8'h00);
    wr(ADR_FSR0_LOW, 8'hA1);
    rdc(ADR_INDF0, 8'h3C);
    wr(ADR_FSR0_LOW, 8'h80);
    rdc(ADR_INDF0, 8'h00);
    wr(ADR_FSR0_HIGH, 8'h10);
    rdc(ADR_INDF0, 8'h00);
    wr(ADR_FSR0_HIGH, 8'h81);
    wr(ADR_INDF0, 8'h11);
    cmp_byte({7'h00, flash_stall}, 8'h01);
    rdc(ADR_INDF0, 8'hDA);
    cmp_byte({7'h00, flash_stall}, 8'h01);
    // second reset in mid-run: counter and flags must clear again
    op(OP_STEP, 11'h000);
    cmp_pc(pc, 15'h0001);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    cmp_pc(pc, PC_RESET);
    rdc(ADR_STACK_FLAGS, 8'h00);
    rdc(ADR_STACK_PTR, 8'h1F);
    test_done;
  end
endmodule
bind pcsi_core pcsi_checker chk (.sys_clk, .rst, .op_valid, .op_code, .op_operand, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pc, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
  .flash_rd, .flash_rdata, .flash_stall, .stack_reset_req);
